// >>> design/tcu_pkg.sv
// Package for the 8-bit timer/counter compare unit: widths, modes, carriers
package tcu_pkg;
	localparam int CNT_W = 8;
	localparam logic [7:0] BOTTOM_VAL = 8'h00;
	localparam logic [7:0] MAX_VAL = 8'hFF;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [1:0] COM_NONE = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;
	localparam logic OC_RESET = 1'b0;
	localparam int WGM_LO_W = 2;

	typedef enum logic [2:0] {
		TCU_WGM_NORMAL = 3'b000,
		TCU_WGM_PC_FF = 3'b001,
		TCU_WGM_CTC = 3'b010,
		TCU_WGM_FAST_FF = 3'b011,
		TCU_WGM_RSV4 = 3'b100,
		TCU_WGM_PC_OCR = 3'b101,
		TCU_WGM_RSV6 = 3'b110,
		TCU_WGM_FAST_OCR = 3'b111
	} tcu_wgm_t;

	// Per-unit configuration from software
	typedef struct packed {
		logic [1:0] com;
		logic force_cmp;
		logic cmp_wr;
		logic [7:0] cmp_wdata;
	} tcu_unit_cfg_t;

	// Per-unit pin-side view
	typedef struct packed {
		logic port_data;
		logic port_dir;
	} tcu_port_t;
endpackage : tcu_pkg

// >>> design/tcu_ocr_buf.sv
// Double-buffered compare value holder for one compare unit
`timescale 1ns/1ps
module tcu_ocr_buf (
	input wire logic mclk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic buffered, // Fast PWM mode: double buffering active
	input wire logic update, // Top/bottom load point on a timer tick
	input wire logic wr, // Software write strobe
	input wire logic [7:0] wdata, // Software write data
	output logic [7:0] buf_value, // Buffer in fast PWM modes, else active value; software view
	output logic [7:0] active_value // Value the comparator uses
);
	logic [7:0] buf_reg;
	logic [7:0] act_reg;
	logic [7:0] buf_next;
	logic [7:0] act_next;

	// ========================================
	// Write steering
	assign buf_next = wr ? wdata : buf_reg;
	assign act_next = (wr && !buffered) ? wdata :
		(buffered && update) ? buf_reg : act_reg;

	always_ff @(posedge mclk) begin
		if (rst) begin
			buf_reg <= 8'h00;
			act_reg <= 8'h00;
		end else begin
			buf_reg <= buf_next;
			act_reg <= act_next;
		end
	end

	// Software reads the buffer in fast PWM modes, the active value otherwise
	assign buf_value = buffered ? buf_reg : act_reg;
	assign active_value = act_reg;
endmodule : tcu_ocr_buf

// >>> design/tcu_wave_unit.sv
// Waveform output state and flag for one compare unit
`timescale 1ns/1ps
module tcu_wave_unit (
	input wire logic mclk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic tick, // Timer tick
	input wire logic match, // Comparator equality, already blocked if needed
	input wire logic is_pwm, // Either fast PWM mode (phase-correct modes not included)
	input wire logic at_bottom_pwm, // Fast PWM wrap to bottom on this tick
	input wire tcu_pkg::tcu_unit_cfg_t cfg, // Mode, force, write
	input wire logic flag_clr, // Write-one clear or interrupt acknowledge
	output logic flag, // Compare flag
	output logic oc_state // Internal compare output state
);
	logic flag_reg;
	logic oc_reg;
	logic flag_next;
	logic oc_next;
	logic act_match;
	logic nonpwm_val;
	logic pwm_match_val;
	logic pwm_bottom_val;

	// ========================================
	// Output state actions
	assign act_match = (tick && match) || (cfg.force_cmp && !is_pwm);
	assign nonpwm_val = (cfg.com == tcu_pkg::COM_TOGGLE) ? !oc_reg :
		(cfg.com == tcu_pkg::COM_CLEAR) ? 1'b0 :
		(cfg.com == tcu_pkg::COM_SET) ? 1'b1 : oc_reg;
	assign pwm_match_val = (cfg.com == tcu_pkg::COM_CLEAR) ? 1'b0 :
		(cfg.com == tcu_pkg::COM_SET) ? 1'b1 :
		(cfg.com == tcu_pkg::COM_TOGGLE) ? !oc_reg : oc_reg;
	assign pwm_bottom_val = (cfg.com == tcu_pkg::COM_CLEAR) ? 1'b1 :
		(cfg.com == tcu_pkg::COM_SET) ? 1'b0 : oc_reg;
	assign oc_next = !is_pwm ? (act_match ? nonpwm_val : oc_reg) :
		(tick && match) ? pwm_match_val :
		at_bottom_pwm ? pwm_bottom_val : oc_reg;
	// Set beats a clear that lands in the same cycle
	assign flag_next = (tick && match) ? 1'b1 : (flag_clr ? 1'b0 : flag_reg);

	always_ff @(posedge mclk) begin
		if (rst) begin
			flag_reg <= 1'b0;
			oc_reg <= tcu_pkg::OC_RESET;
		end else begin
			flag_reg <= flag_next;
			oc_reg <= oc_next;
		end
	end

	assign flag = flag_reg;
	assign oc_state = oc_reg;
endmodule : tcu_wave_unit

// >>> design/tcu_core.sv
// Top of the 8-bit timer/counter with two compare units
`timescale 1ns/1ps
module tcu_core (
	input wire logic mclk, // System clock, 100 MHz
	input wire logic rst, // Synchronous reset, active high
	input wire logic timer_tick_src, // Prescaled or external tick, same domain
	input wire logic [2:0] clock_select_field, // Zero stops the timer
	input wire logic [1:0] wgm_low_a, // Low mode bits from timer_control_a
	input wire logic wgm_high_b, // High mode bit from timer_control_b
	input wire logic counter_wr, // Software write strobe to counter
	input wire logic [7:0] counter_wdata, // Counter write data
	input wire tcu_pkg::tcu_unit_cfg_t cfg_a, // Unit A config and compare write
	input wire tcu_pkg::tcu_unit_cfg_t cfg_b, // Unit B config and compare write
	input wire logic ovf_clr, // Overflow flag clear
	input wire logic flag_a_clr, // Flag A clear
	input wire logic flag_b_clr, // Flag B clear
	input wire logic ovf_int_en, // Overflow interrupt enable
	input wire logic cmp_a_int_en, // Compare A interrupt enable
	input wire logic cmp_b_int_en, // Compare B interrupt enable
	input wire tcu_pkg::tcu_port_t port_a, // General port data/direction, A pin
	input wire tcu_pkg::tcu_port_t port_b, // General port data/direction, B pin
	output logic [7:0] counter_value, // Counter value
	output logic [7:0] compare_value_a, // Compare A, software view
	output logic [7:0] compare_value_b, // Compare B, software view
	output logic overflow_flag, // Overflow flag
	output logic compare_flag_a, // Compare flag A
	output logic compare_flag_b, // Compare flag B
	output logic irq_ovf, // Overflow interrupt request
	output logic irq_cmp_a, // Compare A interrupt request
	output logic irq_cmp_b, // Compare B interrupt request
	output logic wave_out_a, // Pin A output value
	output logic wave_out_a_oe_n, // Pin A output enable, low drives
	output logic wave_out_b, // Pin B output value
	output logic wave_out_b_oe_n // Pin B output enable, low drives
);
	tcu_pkg::tcu_wgm_t wgm;
	logic tick;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic ovf_reg;
	logic ovf_next;
	logic block_reg;
	logic block_next;
	logic is_pwm;
	logic top_is_ocra;
	logic [7:0] top_val;
	logic at_top;
	logic wrap_to_bottom;
	logic clear_ctc;
	logic [7:0] ocr_act [2];
	logic [7:0] ocr_sw [2];
	logic match [2];
	logic flag [2];
	logic oc [2];
	tcu_pkg::tcu_unit_cfg_t cfg [2];
	logic flag_clr [2];
	tcu_pkg::tcu_port_t port [2];
	logic pin_val [2];
	logic pin_oe_n [2];
	logic [7:0] cv_a_reg;
	logic [7:0] cv_b_reg;
	logic fa_reg;
	logic fb_reg;
	logic irq_ovf_reg;
	logic irq_a_reg;
	logic irq_b_reg;
	logic wa_reg;
	logic wa_oe_reg;
	logic wb_reg;
	logic wb_oe_reg;

	// ========================================
	// Mode decode and tick gating
	assign wgm = tcu_pkg::tcu_wgm_t'({wgm_high_b, wgm_low_a});
	// Tick source is prescaler logic on mclk, so no synchroniser here
	assign tick = timer_tick_src && (clock_select_field != tcu_pkg::CS_STOP);
	assign is_pwm = (wgm == tcu_pkg::TCU_WGM_FAST_FF) || (wgm == tcu_pkg::TCU_WGM_FAST_OCR);
	assign top_is_ocra = (wgm == tcu_pkg::TCU_WGM_FAST_OCR) || (wgm == tcu_pkg::TCU_WGM_CTC);
	assign top_val = top_is_ocra ? ocr_act[0] : tcu_pkg::MAX_VAL;
	assign at_top = (cnt_reg == top_val);
	assign clear_ctc = (wgm == tcu_pkg::TCU_WGM_CTC) && match[0];
	// Blocked match still does not stop the counter reaching its top
	assign wrap_to_bottom = is_pwm ? at_top : (wgm == tcu_pkg::TCU_WGM_CTC) ? at_top : 1'b0;

	// ========================================
	// Counter
	always_comb begin
		cnt_next = cnt_reg;
		case (wgm)
			tcu_pkg::TCU_WGM_NORMAL: begin
				if (tick) begin
					cnt_next = cnt_reg + 8'h01;
				end
			end
			tcu_pkg::TCU_WGM_CTC, tcu_pkg::TCU_WGM_FAST_FF, tcu_pkg::TCU_WGM_FAST_OCR: begin
				if (tick) begin
					cnt_next = wrap_to_bottom ? tcu_pkg::BOTTOM_VAL : cnt_reg + 8'h01;
				end
			end
			default: begin
				if (tick) begin
					cnt_next = cnt_reg + 8'h01;
				end
			end
		endcase
		if (counter_wr) begin
			cnt_next = counter_wdata;
		end
	end

	// Overflow: at MAX->0 in normal/CTC, at top in fast PWM
	assign ovf_next = (tick && (is_pwm ? at_top : (cnt_reg == tcu_pkg::MAX_VAL))) ? 1'b1 :
		(ovf_clr ? 1'b0 : ovf_reg);
	// Block holds from the write until the next tick consumes it
	assign block_next = counter_wr ? 1'b1 : (tick ? 1'b0 : block_reg);

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_reg <= 8'h00;
			ovf_reg <= 1'b0;
			block_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			ovf_reg <= ovf_next;
			block_reg <= block_next;
		end
	end

	// ========================================
	// Compare units
	assign cfg[0] = cfg_a;
	assign cfg[1] = cfg_b;
	assign flag_clr[0] = flag_a_clr;
	assign flag_clr[1] = flag_b_clr;
	assign port[0] = port_a;
	assign port[1] = port_b;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_unit
			// Equality only, and blocked after a counter write, so a write equal to compare is lost
			assign match[gi] = (cnt_reg == ocr_act[gi]) && !block_reg;

			tcu_ocr_buf u_buf (
				.mclk(mclk),
				.rst(rst),
				.buffered(is_pwm),
				.update(tick && at_top),
				.wr(cfg[gi].cmp_wr),
				.wdata(cfg[gi].cmp_wdata),
				.buf_value(ocr_sw[gi]),
				.active_value(ocr_act[gi])
			);

			tcu_wave_unit u_wave (
				.mclk(mclk),
				.rst(rst),
				.tick(tick),
				.match(match[gi]),
				.is_pwm(is_pwm),
				.at_bottom_pwm(is_pwm && tick && at_top),
				.cfg(cfg[gi]),
				.flag_clr(flag_clr[gi]),
				.flag(flag[gi]),
				.oc_state(oc[gi])
			);

			assign pin_val[gi] = (cfg[gi].com != tcu_pkg::COM_NONE) ? oc[gi] : port[gi].port_data;
			assign pin_oe_n[gi] = !port[gi].port_dir;
		end
	endgenerate

	// ========================================
	// Registered outputs
	always_ff @(posedge mclk) begin
		if (rst) begin
			cv_a_reg <= 8'h00;
			cv_b_reg <= 8'h00;
			fa_reg <= 1'b0;
			fb_reg <= 1'b0;
			irq_ovf_reg <= 1'b0;
			irq_a_reg <= 1'b0;
			irq_b_reg <= 1'b0;
			wa_reg <= 1'b0;
			wa_oe_reg <= 1'b1;
			wb_reg <= 1'b0;
			wb_oe_reg <= 1'b1;
		end else begin
			cv_a_reg <= ocr_sw[0];
			cv_b_reg <= ocr_sw[1];
			fa_reg <= flag[0];
			fb_reg <= flag[1];
			irq_ovf_reg <= ovf_reg && ovf_int_en;
			irq_a_reg <= flag[0] && cmp_a_int_en;
			irq_b_reg <= flag[1] && cmp_b_int_en;
			wa_reg <= pin_val[0];
			wa_oe_reg <= pin_oe_n[0];
			wb_reg <= pin_val[1];
			wb_oe_reg <= pin_oe_n[1];
		end
	end

	assign counter_value = cnt_reg;
	assign overflow_flag = ovf_reg;
	assign compare_value_a = cv_a_reg;
	assign compare_value_b = cv_b_reg;
	assign compare_flag_a = fa_reg;
	assign compare_flag_b = fb_reg;
	assign irq_ovf = irq_ovf_reg;
	assign irq_cmp_a = irq_a_reg;
	assign irq_cmp_b = irq_b_reg;
	assign wave_out_a = wa_reg;
	assign wave_out_a_oe_n = wa_oe_reg;
	assign wave_out_b = wb_reg;
	assign wave_out_b_oe_n = wb_oe_reg;
endmodule : tcu_core

// >>> dv/tcu_core_chk.sv
// Checker: port-level assertions for the timer/counter
`timescale 1ns/1ps
module tcu_core_chk (
	input wire logic mclk, // Clock
	input wire logic rst, // Reset
	input wire logic timer_tick_src, // Tick
	input wire logic [2:0] clock_select_field, // Select
	input wire logic [1:0] wgm_low_a, // Mode low
	input wire logic wgm_high_b, // Mode high
	input wire logic counter_wr, // Write
	input wire logic [7:0] counter_wdata, // Data
	input wire tcu_pkg::tcu_unit_cfg_t cfg_a, // Unit A
	input wire tcu_pkg::tcu_port_t port_a, // Port A
	input wire logic [7:0] counter_value, // Count
	input wire logic [7:0] compare_value_a, // Compare A
	input wire logic overflow_flag, // Overflow
	input wire logic compare_flag_a, // Flag A
	input wire logic wave_out_a, // Pin A
	input wire logic wave_out_a_oe_n // Enable A
);
// ==========
// Helpers
	// A write in the same cycle wins, so it is no tick
	wire run = timer_tick_src && clock_select_field != 3'h0 && !counter_wr;
	wire up = {wgm_high_b, wgm_low_a} == 3'h0 && run;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
// ==========
// Assertions
	stop_hold_a: assert property (clock_select_field == 3'h0 && !counter_wr |=> $stable(counter_value))
		else $error("counter moved while stopped");
	cpu_write_a: assert property (counter_wr |=> counter_value == $past(counter_wdata))
		else $error("counter write lost");
	count_up_a: assert property (up |=> counter_value == 8'($past(counter_value) + 8'h01))
		else $error("normal count not plus one");
	wrap_ovf_a: assert property (up && &counter_value |=> ~|counter_value && overflow_flag)
		else $error("wrap without overflow");
	// Previous cycle a tick, so no write block is pending
	flag_delay_a: assert property (up && counter_value == compare_value_a && $past(run) |-> ##2 compare_flag_a)
		else $error("compare flag late or missing");
	oe_follow_a: assert property (1'b1 |=> wave_out_a_oe_n == !$past(port_a.port_dir))
		else $error("pin enable wrong");
	port_pass_a: assert property (cfg_a.com == 2'h0 |=> wave_out_a == $past(port_a.port_data))
		else $error("port data not passed");
	reset_clear_a: assert property (disable iff (1'b0) rst |=> ~|counter_value && !overflow_flag && !wave_out_a)
		else $error("reset state wrong");
endmodule : tcu_core_chk
bind tcu_core tcu_core_chk u_chk (.mclk, .rst, .timer_tick_src, .clock_select_field, .wgm_low_a, .wgm_high_b,
	.counter_wr, .counter_wdata, .cfg_a, .port_a, .counter_value, .compare_value_a, .overflow_flag,
	.compare_flag_a, .wave_out_a, .wave_out_a_oe_n);

// >>> dv/test_tcu_core.sv
// Testbench for the timer/counter compare unit
`timescale 1ns/1ps
module test_tcu_core;
	logic mclk = 0, rst = 1, tk = 0, cwr = 0, oclr = 0, aclr = 0, bclr = 0, ien = 0, wh = 0;
	logic [2:0] cs = 3'h1;
	logic [1:0] wl = 2'h0;
	logic [7:0] cd = 8'h00, cv, va, vb;
	logic of, fa, fb, io, ia, ib, wa, wan, wb, wbn;
	tcu_pkg::tcu_unit_cfg_t ca = '0, cb = '0;
	tcu_pkg::tcu_port_t pa = '0, pb = '0;
	// Force table: output mode, force strobe, expected pin
	logic [3:0] fs [6] = '{4'hF, 4'h6, 4'h7, 4'h2, 4'hD, 4'hA};
	int failures = 0, cmp_count = 0, cyc = 0;
	tcu_core dut (.mclk, .rst, .timer_tick_src(tk), .clock_select_field(cs), .wgm_low_a(wl), .wgm_high_b(wh),
		.counter_wr(cwr), .counter_wdata(cd), .cfg_a(ca), .cfg_b(cb), .ovf_clr(oclr), .flag_a_clr(aclr),
		.flag_b_clr(bclr), .ovf_int_en(ien), .cmp_a_int_en(ien), .cmp_b_int_en(ien), .port_a(pa),
		.port_b(pb), .counter_value(cv), .compare_value_a(va), .compare_value_b(vb), .overflow_flag(of),
		.compare_flag_a(fa), .compare_flag_b(fb), .irq_ovf(io), .irq_cmp_a(ia), .irq_cmp_b(ib),
		.wave_out_a(wa), .wave_out_a_oe_n(wan), .wave_out_b(wb), .wave_out_b_oe_n(wbn));
// ==========
// Clock, timeout, helpers
	initial forever #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			results();
		end
	end
	task results;
		if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : results
	// Wide enough for the packed groups of outputs compared at once
	task chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task st(input int n = 1);
		repeat (n) @(posedge mclk);
		#1;
	endtask : st
	task wcnt(input logic [7:0] d);
		cwr = 1;
		cd = d;
		st();
		cwr = 0;
	endtask : wcnt
	task cmpw(input bit b, input logic [7:0] d);
		ca.cmp_wdata = d;
		cb.cmp_wdata = d;
		ca.cmp_wr = !b;
		cb.cmp_wr = b;
		st();
		ca.cmp_wr = 0;
		cb.cmp_wr = 0;
	endtask : cmpw
// ==========
// Scenarios
	task t_stop;
		cs = 3'h0;
		wcnt(8'h5A);
		tk = 1;
		st(3);
		chk(cv, 8'h5A);
		cs = 3'h4;
		wcnt(8'h10);
		chk(cv, 8'h10);
		tk = 0;
		cs = 3'h0;
		cmpw(0, 8'h20);
		wcnt(8'h20);
		st(2);
		cs = 3'h1;
		tk = 1;
		st();
		tk = 0;
		st(3);
		chk({cv, fa}, 9'h042);
	endtask : t_stop
	task t_norm;
		cmpw(0, 8'h03);
		ien = 1;
		wcnt(8'hFD);
		tk = 1;
		for (int i = 1; i < 8; i++) begin
			st();
			chk(cv, 8'(8'hFD + i));
			if (i == 3) chk(of, 1);
		end
		tk = 0;
		chk(fa, 0);
		st();
		chk(fa, 1);
		st(2);
		chk({io, ia}, 2'h3);
		oclr = 1;
		aclr = 1;
		st();
		oclr = 0;
		aclr = 0;
		st(2);
		chk({of, fa}, 2'h0);
	endtask : t_norm
	task t_ctc;
		wl = 2'h2;
		cmpw(0, 8'h05);
		wcnt(8'h00);
		tk = 1;
		for (int i = 1; i < 8; i++) begin
			st();
			chk(cv, 8'(i % 6));
		end
		tk = 0;
		chk(va, 8'h05);
	endtask : t_ctc
	task t_pwm;
		cmpw(1, 8'h80);
		bclr = 1;
		st();
		bclr = 0;
		wl = 2'h3;
		cb.com = 2'h2;
		pb.port_dir = 1;
		cmpw(1, 8'hFE);
		wcnt(8'hFD);
		st();
		chk(vb, 8'hFE);
		tk = 1;
		st(3);
		tk = 0;
		chk({cv, of}, 9'h001);
		st(2);
		chk({fb, wb}, 2'h1);
		wcnt(8'hFD);
		tk = 1;
		st(2);
		tk = 0;
		st(2);
		chk({fb, wb, wbn}, 3'h4);
		chk(ib, 1'b1);
		pb = 2'b10;
		cb.com = 2'h0;
		st(2);
		chk({wb, wbn}, 2'h3);
		wh = 1;
		wcnt(8'h03);
		tk = 1;
		st(3);
		tk = 0;
		chk(cv, 8'h00);
		wh = 0;
		wl = 2'h0;
	endtask : t_pwm
	task t_force;
		cs = 3'h0;
		pa = 2'b01;
		aclr = 1;
		wcnt(8'h33);
		aclr = 0;
		for (int i = 0; i < 6; i++) begin
			if (i == 4) begin
				wl = 2'h3;
				st();
				wl = 2'h0;
			end
			{ca.com, ca.force_cmp} = fs[i][3:1];
			st();
			ca.force_cmp = 0;
			st();
			chk(wa, fs[i][0]);
		end
		chk({cv, fa}, 9'h066);
	endtask : t_force
	initial begin
		st(12);
		rst = 0;
		chk({cv, wa, wan}, 10'h001);
		t_stop();
		t_norm();
		t_ctc();
		t_pwm();
		t_force();
		results();
	end
endmodule : test_tcu_core
